/* File: rtl/nav_io_pkg.sv */
/*
 * Constants, encodings and register map of the navigation sensor digital I/O.
 * Assumes a 200 MHz system clock and a classic Wishbone slave with 32-bit data.
 */
// Function
// - Fix present: 1 ms pulse each second
// - Ack switch low acknowledges all active alerts
// - Overboard switch low one second: emit message
// - Speed-log output pulses last about 50 ms
// - Density 100/200/300/400 pulses per mile
// - Unacknowledged alert drives relay to open contact
// - All acknowledged or inactive: relay released
// - Serial bit rate 4800 to 115200 bps
// - Serial bit rate 38400 bps after reset
package nav_io_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_PER_S      = 1000;

  // Timed behaviour, counted in millisecond ticks
  localparam int PPS_WIDTH_MS  = 1;
  localparam int SLOG_WIDTH_MS = 50;
  localparam int MOB_HOLD_MS   = 1000;
  localparam int DEBOUNCE_MS   = 20;

  // Speed in hundredths of a knot; one pulse per THR of speed*density*ms
  localparam int SPEED_LSB_PER_KN = 100;
  localparam int MS_PER_HOUR      = 3600000;
  localparam logic [31:0] SLOG_THR = 32'(SPEED_LSB_PER_KN * MS_PER_HOUR);
  localparam logic [8:0]  DENS_STEP = 9'h064;

  // Serial bit rate limits and reset values of bit rate, speed and density
  localparam logic [16:0] BAUD_MIN = 17'h012c0;
  localparam logic [16:0] BAUD_MAX = 17'h1c200;
  localparam logic [16:0] BAUD_RST = 17'h09600;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [1:0]  DENS_RST  = 2'h0;

  // Register byte offsets
  localparam logic [7:0] REG_IN_CFG  = 8'h00;
  localparam logic [7:0] REG_OUT_CFG = 8'h04;
  localparam logic [7:0] REG_SPEED   = 8'h08;
  localparam logic [7:0] REG_BAUD    = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_MASK    = 8'h14;
  localparam logic [7:0] REG_STATE   = 8'h18;

  // Field positions
  localparam int OUT_DENS_LSB = 8;
  localparam int STS_ACK      = 0;
  localparam int STS_MOB      = 1;
  localparam int STS_PPS      = 2;
  localparam int STS_W        = 3;

  // Input port function, two bits per port
  typedef enum logic [1:0] {
    FN_NONE = 2'h0,
    FN_ACK  = 2'h1,
    FN_MOB  = 2'h3
  } in_fn_type;

endpackage : nav_io_pkg

/* File: rtl/nav_sensor_digital_io.sv */
/*
 * Digital ports of the navigation sensor: second timing pulse, alert
 * acknowledge and overboard switch inputs, speed-log pulse outputs, alert
 * relay drive and the serial bit-rate setting, behind a Wishbone slave.
 * Assumes switch inputs are asynchronous pins; fix and alert levels come
 * from logic on clk_i.
 */
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module nav_sensor_digital_io #(
  parameter int NI     = 5,
  parameter int NO     = 8,
  parameter int NA     = 8,
  parameter int MS_CYC = nav_io_pkg::CYC_PER_MS
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output var  logic [31:0]   wb_dat_o,
  output var  logic          wb_ack_o,
  output var  logic          irq_o,
  input  wire logic          gnss_fix_i,
  input  wire logic [NA-1:0] alert_active_i,
  input  wire logic [NI-1:0] in_port_rx_p_i,
  output var  logic          second_timing_pulse_out_o,
  output var  logic [NO-1:0] out_port_o,
  output var  logic          relay_no_o,
  output var  logic          mob_msg_o,
  output var  logic [16:0]   baud_o
);
  import nav_io_pkg::*;

  localparam int MS_W = $clog2(MS_CYC);

  typedef struct packed {
    logic [NI-1:0]       sync1;
    logic [NI-1:0]       sync2;
    logic [NI-1:0]       db;
    logic [NI-1:0][4:0]  deb_cnt;
    logic [NI-1:0][9:0]  mob_cnt;
    logic [NI-1:0]       mob_done;
    logic [MS_W-1:0]     cyc_cnt;
    logic                ms_tick;
    logic [9:0]          ms_in_s;
    logic                pps;
    logic [NA-1:0]       acked;
    logic                relay;
    logic [31:0]         acc;
    logic [5:0]          slog_cnt;
    logic                slog_on;
    logic [NO-1:0]       outp;
    logic                mob_msg;
    logic [2*NI-1:0]     in_cfg;
    logic [NO-1:0]       out_en;
    logic [1:0]          dens;
    logic [15:0]         speed;
    logic [16:0]         baud;
    logic [STS_W-1:0]    sts;
    logic [STS_W-1:0]    msk;
    logic                irq;
    logic                ack;
    logic [31:0]         rdat;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic              ack_press;
  logic [NI-1:0]     mob_lvl;
  logic [31:0]       slog_sum;
  logic              sec_edge;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : lane_merge

  // Pulses per mile from the two-bit select: 100, 200, 300 or 400
  function automatic logic [8:0] density(input logic [1:0] sel);
    return 9'(DENS_STEP * ({7'h00, sel} + 9'h001));
  endfunction : density

  // Next-state logic for the whole block
  always_comb begin
    logic        wb_go;
    logic        slog_start;
    logic [31:0] w;
    logic [STS_W-1:0] ev;
    logic [STS_W-1:0] w1c;
    in_fn_type   fn;
    wb_go      = wb_cyc_i && wb_stb_i && !s_r.ack;
    slog_start = 1'b0;
    w          = 32'h00000000;
    ev         = '0;
    w1c        = '0;
    fn         = FN_NONE;
    ack_press  = 1'b0;
    mob_lvl    = '0;
    s_nxt      = s_r;
    s_nxt.ms_tick = 1'b0;
    s_nxt.mob_msg = 1'b0;
    s_nxt.ack     = wb_go;

    // Pins pass two flops before the debouncer sees them
    s_nxt.sync1 = in_port_rx_p_i;
    s_nxt.sync2 = s_r.sync1;

    // Millisecond tick and second boundary
    if (s_r.cyc_cnt == MS_W'(MS_CYC - 1)) begin
      s_nxt.cyc_cnt = '0;
      s_nxt.ms_tick = 1'b1;
    end else begin
      s_nxt.cyc_cnt = s_r.cyc_cnt + MS_W'(1);
    end
    sec_edge = s_r.ms_tick && (s_r.ms_in_s == 10'(MS_PER_S - 1));
    if (s_r.ms_tick) begin
      s_nxt.ms_in_s = sec_edge ? 10'h000 : s_r.ms_in_s + 10'h001;
    end

    // Pulse starts on the second edge only with a fix; ends one tick later
    if (sec_edge && gnss_fix_i) begin
      s_nxt.pps = 1'b1;
    end else if (s_r.ms_tick && PPS_WIDTH_MS == 1) begin
      s_nxt.pps = 1'b0;
    end

    // Debounce: a changed level must hold for the whole debounce time
    for (int i = 0; i < NI; i++) begin
      if (s_r.sync2[i] == s_r.db[i]) begin
        s_nxt.deb_cnt[i] = 5'h00;
      end else if (s_r.ms_tick) begin
        if (s_r.deb_cnt[i] == 5'(DEBOUNCE_MS - 1)) begin
          s_nxt.db[i]      = s_r.sync2[i];
          s_nxt.deb_cnt[i] = 5'h00;
        end else begin
          s_nxt.deb_cnt[i] = s_r.deb_cnt[i] + 5'h01;
        end
      end
      fn = in_fn_type'(s_r.in_cfg[2*i +: 2]);
      // Acknowledge acts on the debounced falling edge, once per press
      if (fn == FN_ACK && s_r.db[i] && !s_nxt.db[i]) begin
        ack_press = 1'b1;
      end
      // Overboard: count held-low milliseconds, fire once, rearm on release
      if (fn == FN_MOB && !s_r.db[i]) begin
        mob_lvl[i] = 1'b1;
        if (s_r.ms_tick && !s_r.mob_done[i]) begin
          if (s_r.mob_cnt[i] == 10'(MOB_HOLD_MS - 1)) begin
            s_nxt.mob_msg     = 1'b1;
            s_nxt.mob_done[i] = 1'b1;
          end else begin
            s_nxt.mob_cnt[i] = s_r.mob_cnt[i] + 10'h001;
          end
        end
      end else begin
        s_nxt.mob_cnt[i]  = 10'h000;
        s_nxt.mob_done[i] = 1'b0;
      end
    end

    // Acknowledge state follows alert activity; a cleared alert rearms
    s_nxt.acked = (s_r.acked | (ack_press ? alert_active_i : '0)) & alert_active_i;
    s_nxt.relay = |(alert_active_i & ~s_nxt.acked);

    // Distance accumulator; threshold is one pulse interval of distance
    // Widen both factors first so the product is not cut to the speed width
    slog_sum = s_r.acc + 32'(s_r.speed) * 32'(density(s_r.dens));
    if (s_r.ms_tick) begin
      if (slog_sum >= SLOG_THR) begin
        s_nxt.acc  = slog_sum - SLOG_THR;
        slog_start = 1'b1;
      end else begin
        s_nxt.acc = slog_sum;
      end
    end
    // Restart wins; at 20 pulses/s or more the pulses merge into a level
    if (slog_start) begin
      s_nxt.slog_on  = 1'b1;
      s_nxt.slog_cnt = 6'h00;
    end else if (s_r.slog_on && s_r.ms_tick) begin
      if (s_r.slog_cnt == 6'(SLOG_WIDTH_MS - 1)) begin
        s_nxt.slog_on = 1'b0;
      end else begin
        s_nxt.slog_cnt = s_r.slog_cnt + 6'h01;
      end
    end
    s_nxt.outp = {NO{s_nxt.slog_on}} & s_r.out_en;

    // Register writes; a bit rate outside the limits is ignored
    if (wb_go && wb_we_i) begin
      unique case (wb_adr_i)
        REG_IN_CFG:  s_nxt.in_cfg = (2*NI)'(lane_merge(32'(s_r.in_cfg), wb_dat_i, wb_sel_i));
        REG_OUT_CFG: begin
          w            = lane_merge({22'h000000, s_r.dens, 8'(s_r.out_en)}, wb_dat_i, wb_sel_i);
          s_nxt.out_en = NO'(w[7:0]);
          s_nxt.dens   = w[OUT_DENS_LSB +: 2];
        end
        REG_SPEED:   s_nxt.speed = 16'(lane_merge({16'h0000, s_r.speed}, wb_dat_i, wb_sel_i));
        REG_BAUD: begin
          w = lane_merge({15'h0000, s_r.baud}, wb_dat_i, wb_sel_i);
          if (w[31:17] == 15'h0000 && w[16:0] >= BAUD_MIN && w[16:0] <= BAUD_MAX) begin
            s_nxt.baud = w[16:0];
          end
        end
        REG_STATUS:  w1c = STS_W'(lane_merge(32'h00000000, wb_dat_i, wb_sel_i));
        REG_MASK:    s_nxt.msk = STS_W'(lane_merge(32'(s_r.msk), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle
    ev[STS_ACK] = ack_press;
    ev[STS_MOB] = s_nxt.mob_msg;
    ev[STS_PPS] = sec_edge && gnss_fix_i;
    s_nxt.sts   = (s_r.sts & ~w1c) | ev;
    s_nxt.irq   = |(s_nxt.sts & s_nxt.msk);

    // Read data; unmapped addresses read zero
    unique case (wb_adr_i)
      REG_IN_CFG:  s_nxt.rdat = 32'(s_r.in_cfg);
      REG_OUT_CFG: s_nxt.rdat = {22'h000000, s_r.dens, 8'(s_r.out_en)};
      REG_SPEED:   s_nxt.rdat = {16'h0000, s_r.speed};
      REG_BAUD:    s_nxt.rdat = {15'h0000, s_r.baud};
      REG_STATUS:  s_nxt.rdat = 32'(s_r.sts);
      REG_MASK:    s_nxt.rdat = 32'(s_r.msk);
      REG_STATE:   s_nxt.rdat = {16'h0000, 4'h0, gnss_fix_i, s_r.relay, s_r.pps, s_r.slog_on, 8'(s_r.db)};
      default:     s_nxt.rdat = 32'h00000000;
    endcase
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r       <= '0;
      s_r.db    <= '1;        // Open switches idle high
      s_r.sync1 <= '1;
      s_r.sync2 <= '1;
      s_r.baud  <= BAUD_RST;
      s_r.speed <= SPEED_RST;
      s_r.dens  <= DENS_RST;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign wb_dat_o                  = s_r.rdat;
  assign wb_ack_o                  = s_r.ack;
  assign irq_o                     = s_r.irq;
  assign second_timing_pulse_out_o = s_r.pps;
  assign out_port_o                = s_r.outp;
  assign relay_no_o                = s_r.relay;
  assign mob_msg_o                 = s_r.mob_msg;
  assign baud_o                    = s_r.baud;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_PPS_NEEDS_FIX: assert property (
    $rose(second_timing_pulse_out_o) |-> $past(gnss_fix_i) && $past(sec_edge))
    else $error("timing pulse rose without fix or off the second");
  AST_PPS_ONE_MS: assert property (
    ce_i && second_timing_pulse_out_o && s_r.ms_tick && !sec_edge |=> !second_timing_pulse_out_o)
    else $error("timing pulse outlived one millisecond");
  AST_ACK_ALL: assert property (
    ce_i && ack_press |=> s_r.acked == $past(alert_active_i))
    else $error("acknowledge missed an active alert");
  AST_MOB_CAUSE: assert property (
    $rose(mob_msg_o) |-> $past(mob_lvl) != '0 && $past(s_r.ms_tick))
    else $error("overboard message without a held switch");
  AST_MOB_ONCE: assert property (
    ce_i && mob_msg_o |-> ##1 (!mob_msg_o || !ce_i))
    else $error("overboard message longer than one cycle");
  AST_SLOG_START: assert property (
    ce_i && s_r.ms_tick && slog_sum >= SLOG_THR |=> s_r.slog_on && s_r.slog_cnt == 6'h00)
    else $error("distance interval reached without a pulse");
  AST_SLOG_END: assert property (
    ce_i && s_r.slog_on && s_r.ms_tick && s_r.slog_cnt == 6'(SLOG_WIDTH_MS - 1)
    && !(slog_sum >= SLOG_THR) |=> !s_r.slog_on)
    else $error("speed-log pulse width wrong");
  AST_RELAY_ON: assert property (
    ce_i && |(alert_active_i & ~s_r.acked) && !ack_press |=> relay_no_o)
    else $error("relay released with an unacknowledged alert");
  AST_RELAY_OFF: assert property (
    ce_i && alert_active_i == '0 |=> !relay_no_o)
    else $error("relay held with no active alert");
  AST_BAUD_RANGE: assert property (
    baud_o >= BAUD_MIN && baud_o <= BAUD_MAX)
    else $error("bit rate outside its limits");
  AST_BAUD_RESET: assert property (
    $past(rst_i) |-> baud_o == BAUD_RST)
    else $error("bit rate not at its reset value");

  COV_PPS:  cover property ($rose(second_timing_pulse_out_o));
  COV_MOB:  cover property ($rose(mob_msg_o));
  COV_SLOG: cover property ($rose(s_r.slog_on) && |s_r.out_en);
  COV_ACK:  cover property (ack_press && |alert_active_i);

endmodule : nav_sensor_digital_io
`default_nettype wire

/* File: testbench/nav_io_far_side.sv */
/*
 * Far side of the digital ports: switch contacts and a pulse receiver.
 * Assumes one clock; switch lines idle high and are pulled low when closed.
 */
`timescale 1ns/1ps
`default_nettype none
module nav_io_far_side (
  input  wire logic       clk_i,
  input  wire logic [4:0] press_i,
  input  wire logic       line_i,
  output wire logic [4:0] rx_p_o,
  output var  int         rises_o,
  output var  int         width_o,
  output var  int         period_o
);
  int   hi = 0;
  int   gap = 0;
  int   rises = 0;
  int   width = 0;
  int   period = 0;
  logic prev = 1'b0;

  // One driver per output: counters live inside, ports only mirror them
  assign rises_o  = rises;
  assign width_o  = width;
  assign period_o = period;

  // A closed contact grounds its line, an open one idles high
  assign rx_p_o = ~press_i;

  // Receiver times each pulse and the spacing of rising edges
  always @(posedge clk_i) begin
    gap  <= gap + 1;
    prev <= line_i;
    if (line_i === 1'b1) hi <= hi + 1;
    if (line_i === 1'b1 && prev !== 1'b1) begin
      rises  <= rises + 1;
      period <= gap;
      gap    <= 1;
      hi     <= 1;
    end
    if (line_i !== 1'b1 && prev === 1'b1) width <= hi;
  end
endmodule : nav_io_far_side
`default_nettype wire

/* File: testbench/test_nav_sensor_digital_io.sv */
/*
 * Self-checking bench for the digital port block over Wishbone.
 * Assumes the shortened millisecond count MS so one second is 20000 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module test_nav_sensor_digital_io;
  import nav_io_pkg::*;
  localparam int MS = 20;
  logic        clk_i, rst_i, cyc, stb, we, fix, ack, irq, pps, relay, mob;
  logic [7:0]  adr, alert, outp;
  logic [31:0] wdat, rdat, q;
  logic [16:0] baud;
  logic [4:0]  press, rx_p;
  int          rises, width, period, prises, pwidth, pperiod, t, n0;
  int          err_count = 0;
  int          num_checks = 0;
  int          mobs = 0;
  logic [31:0] bw[4] = '{32'h000012bf, 32'h0001c201, 32'h000012c0, 32'h0001c200};
  logic [31:0] be[4] = '{32'h00009600, 32'h00009600, 32'h000012c0, 32'h0001c200};

  nav_sensor_digital_io #(.MS_CYC(MS)) nav_sensor_digital_io_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .gnss_fix_i(fix), .alert_active_i(alert),
    .in_port_rx_p_i(rx_p), .second_timing_pulse_out_o(pps), .out_port_o(outp),
    .relay_no_o(relay), .mob_msg_o(mob), .baud_o(baud));
  // Switches and speed-log receiver on output port 0
  nav_io_far_side nav_io_far_side_inst (.clk_i(clk_i), .press_i(press), .line_i(outp[0]),
    .rx_p_o(rx_p), .rises_o(rises), .width_o(width), .period_o(period));
  // Second receiver only times the timing pulse
  nav_io_far_side pps_rx_inst (.clk_i(clk_i), .press_i(5'h00), .line_i(pps),
    .rx_p_o(), .rises_o(prises), .width_o(pwidth), .period_o(pperiod));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Count message pulses; each stands one cycle
  always @(posedge clk_i) if (mob === 1'b1) mobs <= mobs + 1;

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  // Classic cycle: hold until ack is sampled, then drop for one cycle; only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_i); end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
    check_val("ack drop", 0, ack);
  endtask : wb

  task automatic check_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check_val(name, exp, q);
  endtask : check_reg

  task automatic test_done;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; fix = 0; alert = 0; press = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check_val("baud_o", 32'h9600, baud);
    // One past each bit-rate bound is refused, the bounds are taken
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_BAUD, bw[i]);
      check_reg("baud", REG_BAUD, be[i]);
      check_val("baud_o", be[i], baud);
    end
    check_reg("unmapped", 8'h1c, 32'h0);
    // Port 0 acknowledges, port 1 is the overboard switch
    alert <= 8'h03;
    wb(1'b1, REG_IN_CFG, 32'h0000000d);
    wb(1'b1, REG_MASK, 32'h00000007);
    check_val("relay", 1, relay);
    press <= 5'h01;
    t = 0;
    while (relay !== 1'b0 && t < 2000) begin @(posedge clk_i); t++; end
    check_val("relay", 0, relay);
    check_val("irq", 1, irq);
    check_reg("status", REG_STATUS, 32'h1);
    press <= 5'h00;
    wb(1'b1, REG_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    check_val("irq", 0, irq);
    alert <= 8'h07;
    repeat (3) @(posedge clk_i);
    check_val("relay", 1, relay);
    // A press shorter than a second sends nothing, a long one sends once
    press <= 5'h02;
    repeat (300 * MS) @(posedge clk_i);
    press <= 5'h00;
    repeat (50 * MS) @(posedge clk_i);
    check_val("mob short", 0, mobs);
    press <= 5'h02;
    repeat (1100 * MS) @(posedge clk_i);
    press <= 5'h00;
    check_val("mob", 1, mobs);
    check_reg("status", REG_STATUS, 32'h2);
    check_val("pps no fix", 0, prises);
    // With a fix the pulse repeats each second and lasts one millisecond
    fix <= 1'b1;
    t = 0;
    while (prises < 2 && t < 45000) begin @(posedge clk_i); t++; end
    repeat (2 * MS) @(posedge clk_i);
    check_val("pps width", MS, pwidth);
    check_val("pps period", 1000 * MS, pperiod);
    // Fix set, alert 2 unacknowledged, switches released, no pulses
    check_reg("state", REG_STATE, 32'h00000c1f);
    // Speed times density is 6e6 per ms for every density: one pulse each 60 ms
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, REG_SPEED, 32'(60000 / (d + 1)));
      wb(1'b1, REG_OUT_CFG, 32'((d << 8) | 1));
      n0 = rises;
      t = 0;
      while (rises < n0 + 3 && t < 6000) begin @(posedge clk_i); t++; end
      check_val("log period", 60 * MS, period);
      check_val("log width", 50 * MS, width);
      check_val("other ports", 0, outp[7:1]);
    end
    test_done();
  end

  // Whole run is about 75000 cycles
  initial begin
    repeat (95000) @(posedge clk_i);
    err_count++;
    test_done();
  end
endmodule : test_nav_sensor_digital_io
`default_nettype wire
